// >>> qtc_map.svh
// Constants for the quad timer/counter: mode register field positions,
// clock select codes, prescaler tap masks and reset values.
// Assumes it is included by its bare name from every file that needs it.
`ifndef QTC_MAP_SVH
`define QTC_MAP_SVH

// Even channel mode register fields (channels 0 and 2).
`define QTC_EVEN_CS_HI        2
`define QTC_EVEN_CS_LO        0
`define QTC_EVEN_CAP_BIT      3

// Odd channel mode register fields (channels 1 and 3).
`define QTC_ODD_CS_HI         1
`define QTC_ODD_CS_LO         0
`define QTC_ODD_WIDE_BIT      2
`define QTC_ODD_CAP_BIT       3

// Even channel clock select codes.
`define QTC_CS_E_DIV2         3'h0
`define QTC_CS_E_DIV4         3'h1
`define QTC_CS_E_DIV8         3'h2
`define QTC_CS_E_DIV32        3'h3
`define QTC_CS_E_DIV128       3'h4
`define QTC_CS_E_DIV512       3'h5
`define QTC_CS_E_DIV2048      3'h6
`define QTC_CS_E_EVENT        3'h7

// Odd channel clock select codes; the last one, together with the pair bit, enables pairing.
`define QTC_CS_O_DIV1         2'h0
`define QTC_CS_O_DIV2         2'h1
`define QTC_CS_O_DIV8         2'h2
`define QTC_CS_O_CASCADE      2'h3

// Prescaler tap masks: a tap fires when all masked bits are one.
`define QTC_PRE_W             11
`define QTC_MASK_DIV1         11'h000
`define QTC_MASK_DIV2         11'h001
`define QTC_MASK_DIV4         11'h003
`define QTC_MASK_DIV8         11'h007
`define QTC_MASK_DIV32        11'h01F
`define QTC_MASK_DIV128       11'h07F
`define QTC_MASK_DIV512       11'h1FF
`define QTC_MASK_DIV2048      11'h7FF

// Edge select codes for the external interrupt inputs.
`define QTC_EDGE_FALL         2'h0
`define QTC_EDGE_RISE         2'h1

// Reset values.
`define QTC_PRE_RST           11'h000
`define QTC_CNT_RST           8'h00
`define QTC_CAP_RST           8'h00
`define QTC_FLAG_RST          4'h0

`endif

// >>> qtc_pkg.sv
// Types shared by the quad timer/counter files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package qtc_pkg;

  // How a channel pair is operating.
  typedef enum logic [0:0] {
    QTC_PAIR_SPLIT,
    QTC_PAIR_WIDE
  } qtc_pair_mode_t;

endpackage : qtc_pkg
`default_nettype wire

// >>> qtc_edge.sv
// Synchroniser and edge detector for one input pin.
// Assumes the pin is slow against clk_sys and one pulse per edge is wanted.
`timescale 1ns/1ps
`default_nettype none
`include "qtc_map.svh"

module qtc_edge (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);

  logic sync1_r;
  logic sync2_r;
  logic last_r;
  wire  rise_w;
  wire  fall_w;

  // Only the second stage and the history stage feed the detector.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  // Each selected edge yields exactly one pulse of one cycle.
  assign rise_w = sync2_r & ~last_r;
  assign fall_w = ~sync2_r & last_r;
  assign edge_pulse = (edge_sel == `QTC_EDGE_FALL) ? fall_w :
                      (edge_sel == `QTC_EDGE_RISE) ? rise_w :
                      (rise_w | fall_w);

endmodule : qtc_edge
`default_nettype wire

// >>> qtc_top.sv
// Top of the quad timer/counter: prescaler, two channel pairs, flags.
// Assumes mode, match and enable values are held steady by outside
// registers, and all pins are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "qtc_map.svh"

module qtc_top (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] mode_ch0,
  input  wire logic [7:0] mode_ch1,
  input  wire logic [7:0] mode_ch2,
  input  wire logic [7:0] mode_ch3,
  input  wire logic [7:0] match_ch0,
  input  wire logic [7:0] match_ch1,
  input  wire logic [7:0] match_ch2,
  input  wire logic [7:0] match_ch3,
  input  wire logic [3:0] run_en,
  input  wire logic       event_input_pin,
  input  wire logic       event_pin_enable,
  input  wire logic [3:0] external_irq_input,
  input  wire logic [7:0] irq_edge_select_reg,
  input  wire logic       compare_enable,
  input  wire logic [3:0] irq_flag_clr,
  input  wire logic [3:0] ext_flag_clr,
  output logic      [7:0] count_ch0,
  output logic      [7:0] count_ch1,
  output logic      [7:0] count_ch2,
  output logic      [7:0] count_ch3,
  output logic      [7:0] capture_ch0,
  output logic      [7:0] capture_ch1,
  output logic      [7:0] capture_ch2,
  output logic      [7:0] capture_ch3,
  output logic      [7:0] read_data_zero,
  output logic      [3:0] channel_irq_flag,
  output logic      [3:0] ext_irq_flag,
  output logic            compare_out
);

  // Tap decode for the even channels; code 111 is not a prescaler tap.
  function automatic logic tap_even(input logic [2:0] cs,
                                    input logic [`QTC_PRE_W-1:0] pre);
    logic [`QTC_PRE_W-1:0] mask;
    mask = `QTC_MASK_DIV2;
    case (cs)
      `QTC_CS_E_DIV2:    mask = `QTC_MASK_DIV2;
      `QTC_CS_E_DIV4:    mask = `QTC_MASK_DIV4;
      `QTC_CS_E_DIV8:    mask = `QTC_MASK_DIV8;
      `QTC_CS_E_DIV32:   mask = `QTC_MASK_DIV32;
      `QTC_CS_E_DIV128:  mask = `QTC_MASK_DIV128;
      `QTC_CS_E_DIV512:  mask = `QTC_MASK_DIV512;
      `QTC_CS_E_DIV2048: mask = `QTC_MASK_DIV2048;
      default:           mask = `QTC_MASK_DIV2;
    endcase
    tap_even = (cs != `QTC_CS_E_EVENT) && ((pre & mask) == mask);
  endfunction : tap_even

  // Tap decode for the odd channels; the cascade code gives no tap of its own.
  function automatic logic tap_odd(input logic [1:0] cs,
                                   input logic [`QTC_PRE_W-1:0] pre);
    logic [`QTC_PRE_W-1:0] mask;
    mask = `QTC_MASK_DIV1;
    case (cs)
      `QTC_CS_O_DIV1: mask = `QTC_MASK_DIV1;
      `QTC_CS_O_DIV2: mask = `QTC_MASK_DIV2;
      `QTC_CS_O_DIV8: mask = `QTC_MASK_DIV8;
      default:        mask = `QTC_MASK_DIV1;
    endcase
    tap_odd = (cs != `QTC_CS_O_CASCADE) && ((pre & mask) == mask);
  endfunction : tap_odd

  logic [`QTC_PRE_W-1:0] pre_r;
  logic [3:0]            irq_flag_r;
  logic [3:0]            ext_flag_r;
  logic [7:0]            read_zero_r;
  logic                  compare_r;
  wire  [3:0]            irq_set_w;
  wire  [3:0]            ext_pulse_w;
  wire                   event_pulse_w;
  wire                   event_pin_w;
  wire                   compare_toggle_w;

  // Free-running prescaler; every divided rate is a one-cycle tap of it.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pre_r <= `QTC_PRE_RST;
    else
      pre_r <= pre_r + 11'h001;
  end

  // The pin is gated by its enable; software owns direction setup.
  assign event_pin_w = event_input_pin & event_pin_enable;

  qtc_edge u_event_edge (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_in     (event_pin_w),
    .edge_sel   (`QTC_EDGE_RISE),
    .edge_pulse (event_pulse_w)
  );

  // One detector per external interrupt input, with its own edge choice.
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_ext
      qtc_edge u_ext_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     (external_irq_input[k]),
        .edge_sel   (irq_edge_select_reg[2*k+1:2*k]),
        .edge_pulse (ext_pulse_w[k])
      );
    end
  endgenerate

  // Two pairs, alike except for the event source: even channel 2p and odd channel 2p+1.
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_pair
      logic [7:0]           cnt_e_r;
      logic [7:0]           cnt_o_r;
      logic [7:0]           cap_e_r;
      logic [7:0]           cap_o_r;
      logic [7:0]           cnt_e_nxt;
      logic [7:0]           cnt_o_nxt;
      logic [7:0]           cap_e_nxt;
      logic [7:0]           cap_o_nxt;
      logic                 set_e;
      logic                 set_o;
      logic [15:0]          cnt16_inc;
      wire  [7:0]           mode_e;
      wire  [7:0]           mode_o;
      wire  [7:0]           mat_e;
      wire  [7:0]           mat_o;
      wire  [2:0]           cs_e;
      wire  [1:0]           cs_o;
      wire                  wide_w;
      wire                  ev_src_w;
      wire                  tick_e;
      wire                  tick_o;
      wire                  cap_trig_e;
      wire                  cap_trig_o;
      wire                  hit_e;
      wire                  hit_o;
      wire                  hit16;
      qtc_pkg::qtc_pair_mode_t pair_mode;

      // Field decode of the two mode registers of this pair.
      assign mode_e = (p == 0) ? mode_ch0 : mode_ch2;
      assign mode_o = (p == 0) ? mode_ch1 : mode_ch3;
      assign mat_e  = (p == 0) ? match_ch0 : match_ch2;
      assign mat_o  = (p == 0) ? match_ch1 : match_ch3;
      assign cs_e   = mode_e[`QTC_EVEN_CS_HI:`QTC_EVEN_CS_LO];
      assign cs_o   = mode_o[`QTC_ODD_CS_HI:`QTC_ODD_CS_LO];

      // Pairing needs both the pair bit and the cascade select; otherwise 8-bit.
      assign wide_w = mode_o[`QTC_ODD_WIDE_BIT] && (cs_o == `QTC_CS_O_CASCADE);
      assign pair_mode = wide_w ? qtc_pkg::QTC_PAIR_WIDE : qtc_pkg::QTC_PAIR_SPLIT;

      // Only pair 0 has an event source; channel 2 never counts events.
      assign ev_src_w = (p == 0) ? event_pulse_w : 1'b0;
      assign tick_e = run_en[2*p] &&
                      ((cs_e == `QTC_CS_E_EVENT) ? ev_src_w : tap_even(cs_e, pre_r));
      assign tick_o = run_en[2*p+1] && tap_odd(cs_o, pre_r);

      // A capture edge needs the channel's capture bit.
      assign cap_trig_e = mode_e[`QTC_EVEN_CAP_BIT] && ext_pulse_w[2*p];
      assign cap_trig_o = mode_o[`QTC_ODD_CAP_BIT] && ext_pulse_w[2*p+1] && !wide_w;

      // Equality compares; a zero match is a software fault, left unguarded.
      assign hit_e = (cnt_e_r == mat_e);
      assign hit_o = (cnt_o_r == mat_o);
      assign hit16 = ({cnt_o_r, cnt_e_r} == {mat_o, mat_e});
      assign cnt16_inc = {cnt_o_r, cnt_e_r} + 16'h0001;

      // Next count and capture values; capture beats a tick in the same cycle.
      always_comb
      begin
        cnt_e_nxt = cnt_e_r;
        cnt_o_nxt = cnt_o_r;
        cap_e_nxt = cap_e_r;
        cap_o_nxt = cap_o_r;
        set_e     = 1'b0;
        set_o     = 1'b0;
        case (pair_mode)
          qtc_pkg::QTC_PAIR_SPLIT:
          begin
            if (cap_trig_e)
            begin
              cap_e_nxt = cnt_e_r;
              cnt_e_nxt = `QTC_CNT_RST;
            end
            else if (tick_e)
            begin
              cnt_e_nxt = hit_e ? `QTC_CNT_RST : cnt_e_r + 8'h01;
              set_e     = hit_e;
            end
            if (cap_trig_o)
            begin
              cap_o_nxt = cnt_o_r;
              cnt_o_nxt = `QTC_CNT_RST;
            end
            else if (tick_o)
            begin
              cnt_o_nxt = hit_o ? `QTC_CNT_RST : cnt_o_r + 8'h01;
              set_o     = hit_o;
            end
          end
          qtc_pkg::QTC_PAIR_WIDE:
          begin
            if (cap_trig_e)
            begin
              cap_e_nxt = cnt_e_r;
              cap_o_nxt = cnt_o_r;
              cnt_e_nxt = `QTC_CNT_RST;
              cnt_o_nxt = `QTC_CNT_RST;
            end
            else if (tick_e)
            begin
              cnt_e_nxt = hit16 ? `QTC_CNT_RST : cnt16_inc[7:0];
              cnt_o_nxt = hit16 ? `QTC_CNT_RST : cnt16_inc[15:8];
              set_e     = hit16;
            end
          end
          default:
          begin
            cnt_e_nxt = cnt_e_r;
          end
        endcase
      end

      // Count and capture storage of the pair.
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          cnt_e_r <= `QTC_CNT_RST;
          cnt_o_r <= `QTC_CNT_RST;
          cap_e_r <= `QTC_CAP_RST;
          cap_o_r <= `QTC_CAP_RST;
        end
        else
        begin
          cnt_e_r <= cnt_e_nxt;
          cnt_o_r <= cnt_o_nxt;
          cap_e_r <= cap_e_nxt;
          cap_o_r <= cap_o_nxt;
        end
      end

      assign irq_set_w[2*p]   = set_e;
      assign irq_set_w[2*p+1] = set_o;
    end
  endgenerate

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_flag_r <= `QTC_FLAG_RST;
      ext_flag_r <= `QTC_FLAG_RST;
    end
    else
    begin
      irq_flag_r <= irq_set_w | (irq_flag_r & ~irq_flag_clr);
      ext_flag_r <= ext_pulse_w | (ext_flag_r & ~ext_flag_clr);
    end
  end

  // Channel 2 match drives a square wave on the compare pin; the PWM of
  // channel 3 is not built here, so that channel stays a plain timer.
  assign compare_toggle_w = compare_enable && irq_set_w[2];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      compare_r <= 1'b0;
    else if (compare_toggle_w)
      compare_r <= ~compare_r;
  end

  // Shared channel 0 read port, registered so it lags the count by a cycle.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      read_zero_r <= `QTC_CNT_RST;
    else if (mode_ch0[`QTC_EVEN_CAP_BIT])
      read_zero_r <= g_pair[0].cap_e_r;
    else
      read_zero_r <= g_pair[0].cnt_e_r;
  end

  // Outputs taken straight from the storage flip-flops.
  assign count_ch0        = g_pair[0].cnt_e_r;
  assign count_ch1        = g_pair[0].cnt_o_r;
  assign count_ch2        = g_pair[1].cnt_e_r;
  assign count_ch3        = g_pair[1].cnt_o_r;
  assign capture_ch0      = g_pair[0].cap_e_r;
  assign capture_ch1      = g_pair[0].cap_o_r;
  assign capture_ch2      = g_pair[1].cap_e_r;
  assign capture_ch3      = g_pair[1].cap_o_r;
  assign read_data_zero   = read_zero_r;
  assign channel_irq_flag = irq_flag_r;
  assign ext_irq_flag     = ext_flag_r;
  assign compare_out      = compare_r;

endmodule : qtc_top
`default_nettype wire

// >>> qtc_props.sv
// Concurrent checks on the ports of the quad timer/counter top.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/1ps
`default_nettype none

module qtc_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] mode_ch0,
  input wire logic [7:0] mode_ch1,
  input wire logic [7:0] match_ch0,
  input wire logic [7:0] match_ch1,
  input wire logic [3:0] run_en,
  input wire logic       event_pin_enable,
  input wire logic [7:0] count_ch0,
  input wire logic [7:0] count_ch1,
  input wire logic [7:0] capture_ch0,
  input wire logic [7:0] read_data_zero,
  input wire logic [3:0] channel_irq_flag,
  input wire logic [3:0] ext_irq_flag
);
  logic pair_on;

  // Pairing needs the pair bit and the cascade select together.
  assign pair_on = mode_ch1[2] && (mode_ch1[1:0] == 2'h3);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // A match flag appears only on the wrap from the match value back to zero.
  chk_wrap_at_match: assert property ($rose(channel_irq_flag[0]) |->
    count_ch0 == 8'h00 && $past(count_ch0) == $past(match_ch0)) else $error("wrap mismatch");
  chk_count_step: assert property ($changed(count_ch1) |->
    count_ch1 == 8'h00 || count_ch1 == 8'($past(count_ch1) + 8'h01)) else $error("bad step");
  // The mode must be steady for a cycle, since a fresh select may tick at once.
  chk_div2_gap: assert property ($changed(count_ch0) && mode_ch0[3:0] == 4'h0 &&
    $stable(mode_ch0) |=> $stable(count_ch0)) else $error("divide by two too fast");
  // The release edge still resets the counts, so no step is owed from it.
  chk_div1_step: assert property (!rst && mode_ch1[3:0] == 4'h0 && run_en[1] &&
    count_ch1 != match_ch1 |=> count_ch1 == 8'($past(count_ch1) + 8'h01)) else $error("div1");
  chk_capture_take: assert property ($changed(capture_ch0) |->
    count_ch0 == 8'h00 && capture_ch0 == $past(count_ch0)) else $error("capture value");
  chk_capture_flag: assert property ($changed(capture_ch0) |-> ext_irq_flag[0])
    else $error("capture without flag");
  chk_read_capture: assert property (mode_ch0[3] |=> read_data_zero == $past(capture_ch0))
    else $error("read port not capture");
  chk_read_count: assert property (!mode_ch0[3] |=> read_data_zero == $past(count_ch0))
    else $error("read port not count");
  chk_wide_quiet: assert property (pair_on && !channel_irq_flag[1] |=>
    !channel_irq_flag[1]) else $error("odd flag in pair mode");
  chk_event_gate: assert property ((mode_ch0[3:0] == 4'h7 && !event_pin_enable) [*5] |=>
    $stable(count_ch0)) else $error("event counted while gated");

  cover property ($changed(capture_ch0));
  cover property (pair_on && $rose(channel_irq_flag[0]));
  cover property (mode_ch0[2:0] == 3'h7 && $changed(count_ch0));
endmodule : qtc_props

bind qtc_top qtc_props i_qtc_props (
  .clk_sys(clk_sys), .rst(rst), .mode_ch0(mode_ch0), .mode_ch1(mode_ch1),
  .match_ch0(match_ch0), .match_ch1(match_ch1), .run_en(run_en),
  .event_pin_enable(event_pin_enable), .count_ch0(count_ch0), .count_ch1(count_ch1),
  .capture_ch0(capture_ch0), .read_data_zero(read_data_zero),
  .channel_irq_flag(channel_irq_flag), .ext_irq_flag(ext_irq_flag));
`default_nettype wire

// >>> qtc_pin_model.sv
// Outside world of the timer: the event pin and the external interrupt pins.
// Assumes the caller runs in the bench process; pins idle low.
`timescale 1ns/1ps
`default_nettype none

module qtc_pin_model (
  input wire logic        clk_sys,
  output var logic        event_input_pin,
  output var logic  [3:0] external_irq_input
);
  // Pins start low, as a quiet source would leave them.
  initial
  begin
    event_input_pin    = 1'b0;
    external_irq_input = 4'h0;
  end

  // Slow pulses, two cycles high and three low, so the synchroniser sees each one.
  task automatic event_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      event_input_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
      event_input_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : event_pulses

  // One level change on an external interrupt pin.
  task automatic set_irq_pin(input int k, input logic lvl);
    @(posedge clk_sys);
    external_irq_input[k] <= lvl;
  endtask : set_irq_pin
endmodule : qtc_pin_model
`default_nettype wire

// >>> quad_timer_counter_8bit_test.sv
// Self-checking bench for the quad timer/counter top.
// Assumes qtc_props is bound to qtc_top and the pin model drives the pins.
`timescale 1ns/1ps
`default_nettype none

module quad_timer_counter_8bit_test;
  logic       clk_sys, rst, event_pin_enable, compare_enable, event_input_pin, compare_out;
  logic [7:0] mode_ch0, mode_ch1, mode_ch2, mode_ch3, match_ch0, match_ch1, match_ch2, match_ch3;
  logic [7:0] count_ch0, count_ch1, count_ch2, count_ch3, capture_ch0, read_data_zero, snap;
  logic [7:0] irq_edge_select_reg;
  logic [7:0] capture_ch2;
  logic       ev_prev;
  logic [3:0] run_en, irq_flag_clr, ext_flag_clr, external_irq_input;
  logic [3:0] channel_irq_flag, ext_irq_flag;
  int         mismatches, total_checks, cycles, n, ev_model;
  integer     seed = 32'hd373;
  int         evd[7] = '{2, 4, 8, 32, 128, 512, 2048};
  int         odd[3] = '{1, 2, 8};
  int         m[4];

  qtc_top i_qtc_top (.clk_sys(clk_sys), .rst(rst), .mode_ch0(mode_ch0), .mode_ch1(mode_ch1),
    .mode_ch2(mode_ch2), .mode_ch3(mode_ch3), .match_ch0(match_ch0), .match_ch1(match_ch1),
    .match_ch2(match_ch2), .match_ch3(match_ch3), .run_en(run_en),
    .event_input_pin(event_input_pin), .event_pin_enable(event_pin_enable),
    .external_irq_input(external_irq_input), .irq_edge_select_reg(irq_edge_select_reg),
    .compare_enable(compare_enable), .irq_flag_clr(irq_flag_clr), .ext_flag_clr(ext_flag_clr),
    .count_ch0(count_ch0), .count_ch1(count_ch1), .count_ch2(count_ch2), .count_ch3(count_ch3),
    .capture_ch0(capture_ch0), .capture_ch1(), .capture_ch2(capture_ch2), .capture_ch3(),
    .read_data_zero(read_data_zero), .channel_irq_flag(channel_irq_flag),
    .ext_irq_flag(ext_irq_flag), .compare_out(compare_out));

  qtc_pin_model i_qtc_pin_model (.clk_sys(clk_sys), .event_input_pin(event_input_pin),
    .external_irq_input(external_irq_input));

  // Half-period inversion gives the 50 ns clock.
  always #25 clk_sys = ~clk_sys;

  // Reference event count: one count per rise of the pin as gated by its enable.
  // It is sampled on the same edges as the design, so only the latency differs.
  always @(posedge clk_sys)
  begin
    if (rst)
      ev_model <= 0;
    else if (event_input_pin && event_pin_enable && !ev_prev)
      ev_model <= ev_model + 1;
    ev_prev <= event_input_pin && event_pin_enable;
  end

  // A hang is cut short well above the longest expected run.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // Reset also restarts the prescaler, so each period starts from a known phase.
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
  endtask : do_reset

  // Clears a flag, then waits for it to be set again; the flag is sticky.
  task automatic wait_flag(input int ch, output time t, output logic cmp);
    int k;
    @(posedge clk_sys);
    irq_flag_clr[ch] <= 1'b1;
    @(posedge clk_sys);
    irq_flag_clr[ch] <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while (channel_irq_flag[ch] !== 1'b1 && k < 20000);
    t = $time;
    cmp = compare_out;
  endtask : wait_flag

  // Time between two wraps, in clock cycles.
  task automatic measure(input int ch, input int exp);
    time  t0, t1;
    logic c0, c1;
    wait_flag(ch, t0, c0);
    wait_flag(ch, t1, c1);
    check(16'((t1 - t0) / 50), 16'(exp));
    if (ch == 2)
      check(c0 ^ c1, 1'b1);
  endtask : measure

  // Main sequence: dividers, run gate, events, capture, edge selects, pairing.
  initial
  begin
    clk_sys = 1'b0; rst = 1'b1; run_en = 4'hF; event_pin_enable = 1'b0; compare_enable = 1'b1;
    {mode_ch0, mode_ch1, mode_ch2, mode_ch3} = 32'h0;
    {match_ch0, match_ch1, match_ch2, match_ch3} = 32'h01010101;
    irq_edge_select_reg = 8'h00; irq_flag_clr = 4'h0; ext_flag_clr = 4'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check({count_ch0, count_ch3}, 16'h0000);
    check({channel_irq_flag, ext_irq_flag, read_data_zero}, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      m[0] = (evd[i] >= 32) ? 2 : 1 + ($random(seed) & 63);
      m[2] = (evd[i] >= 32) ? 1 : 1 + ($random(seed) & 63);
      m[1] = 1 + ($random(seed) & 63);
      m[3] = 1 + ($random(seed) & 63);
      do_reset();
      @(posedge clk_sys);
      mode_ch0 <= 8'(i); mode_ch2 <= 8'(i); mode_ch1 <= 8'(i % 3); mode_ch3 <= 8'(i % 3);
      {match_ch0, match_ch1, match_ch2, match_ch3} <= {8'(m[0]), 8'(m[1]), 8'(m[2]), 8'(m[3])};
      for (int c = 0; c < 4; c++)
        measure(c, (m[c] + 1) * ((c % 2 == 0) ? evd[i] : odd[i % 3]));
    end
    @(posedge clk_sys);
    run_en <= 4'h0;
    @(negedge clk_sys);
    snap = count_ch1;
    repeat (20) @(negedge clk_sys);
    check(count_ch1, snap);
    do_reset();
    @(posedge clk_sys);
    run_en <= 4'hF; mode_ch0 <= 8'h07; mode_ch2 <= 8'h07; match_ch0 <= 8'hFF;
    event_pin_enable <= 1'b1;
    n = 1 + ($random(seed) & 15);
    i_qtc_pin_model.event_pulses(n);
    repeat (6) @(negedge clk_sys);
    check(count_ch0, 16'(n));
    check(count_ch0, 16'(ev_model));
    check(count_ch2, 8'h00);
    @(posedge clk_sys);
    event_pin_enable <= 1'b0;
    i_qtc_pin_model.event_pulses(3);
    repeat (6) @(negedge clk_sys);
    check(count_ch0, 16'(n));
    check(count_ch0, 16'(ev_model));
    do_reset();
    @(posedge clk_sys);
    mode_ch0 <= 8'h08; mode_ch2 <= 8'h08; irq_edge_select_reg <= 8'h11;
    match_ch0 <= 8'hFF; match_ch2 <= 8'hFF;
    repeat (40) @(negedge clk_sys);
    snap = count_ch0;
    i_qtc_pin_model.set_irq_pin(0, 1'b1);
    repeat (6) @(negedge clk_sys);
    check(ext_irq_flag[0], 1'b1);
    check(8'(capture_ch0 - snap) <= 8'h04, 1'b1);
    check(count_ch0 <= 8'h03, 1'b1);
    i_qtc_pin_model.set_irq_pin(0, 1'b0);
    @(negedge clk_sys);
    snap = count_ch2;
    i_qtc_pin_model.set_irq_pin(2, 1'b1);
    repeat (6) @(negedge clk_sys);
    check(ext_irq_flag[2], 1'b1);
    check(8'(capture_ch2 - snap) <= 8'h04, 1'b1);
    check(count_ch2 <= 8'h03, 1'b1);
    i_qtc_pin_model.set_irq_pin(2, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_sys);
      irq_edge_select_reg <= {4'h0, 2'(c), 2'h1};
      ext_flag_clr <= 4'hF;
      @(posedge clk_sys);
      ext_flag_clr <= 4'h0;
      i_qtc_pin_model.set_irq_pin(1, 1'b1);
      repeat (6) @(negedge clk_sys);
      check(ext_irq_flag[1], c != 0);
      @(posedge clk_sys);
      ext_flag_clr <= 4'hF;
      @(posedge clk_sys);
      ext_flag_clr <= 4'h0;
      i_qtc_pin_model.set_irq_pin(1, 1'b0);
      repeat (6) @(negedge clk_sys);
      check(ext_irq_flag[1], c != 1);
    end
    do_reset();
    @(posedge clk_sys);
    mode_ch0 <= 8'h00; mode_ch1 <= 8'h07; match_ch0 <= 8'h03; match_ch1 <= 8'h01;
    measure(0, 520);
    check(channel_irq_flag[1], 1'b0);
    give_verdict();
  end
endmodule : quad_timer_counter_8bit_test
`default_nettype wire
